// >>> dv/afpo_capture_model.sv
`timescale 1ns/1ps
module afpo_capture_model (
  input  wire logic        i_rise_launch,
  input  wire logic        i_opp,
  input  wire logic        i_clk,
  input  wire logic        i_clk_oe,
  input  wire logic [23:0] i_pri,
  input  wire logic [23:0] i_sec,
  input  wire logic [5:0]  i_oe,
  input  wire logic        i_hs,
  input  wire logic        i_vs,
  output logic      [23:0] o_pri,
  output logic      [23:0] o_sec,
  output logic      [1:0]  o_hv,
  output int               o_caps,
  output int               o_hs_high,
  output int               o_errs
);
  // ----------------------------------------------------------------
  // Undriven pins sit at the pull-down level
  // ----------------------------------------------------------------
  logic        ck;
  logic [23:0] pri_w;
  logic [23:0] sec_w;
  logic [23:0] pri_s;
  logic [23:0] sec_s;
  logic [1:0]  hv_s;
  assign ck    = i_clk_oe & i_clk;
  assign pri_w = {i_oe[0] ? i_pri[23:16] : 8'h00,
                  i_oe[2] ? i_pri[15:8] : 8'h00,
                  i_oe[4] ? i_pri[7:0] : 8'h00};
  assign sec_w = {i_oe[1] ? i_sec[23:16] : 8'h00,
                  i_oe[3] ? i_sec[15:8] : 8'h00,
                  i_oe[5] ? i_sec[7:0] : 8'h00};
  initial
  begin
    o_caps    = 0;
    o_hs_high = 0;
    o_errs    = 0;
  end
  // Snapshot 1 ns after every edge; a value that moves between its
  // launch edge and the capture edge would be torn in real capture
  always @(ck)
  begin
    #1;
    if (ck == i_rise_launch)
    begin
      pri_s = pri_w;
      hv_s  = {i_hs, i_vs};
      if (i_opp && sec_w !== sec_s)
        o_errs++;
      if (i_opp)
        o_sec = sec_w;
      else
        sec_s = sec_w;
    end
    else
    begin
      if ({pri_w, i_hs, i_vs} !== {pri_s, hv_s})
        o_errs++;
      if (!i_opp && sec_w !== sec_s)
        o_errs++;
      if (i_opp)
        sec_s = sec_w;
      else
        o_sec = sec_w;
      o_pri = pri_w;
      o_hv  = {i_hs, i_vs};
      o_caps++;
      o_hs_high += i_hs;
    end
  end
endmodule

// >>> dv/tb_afpo_formatter.sv
`timescale 1ns/1ps
module tb_afpo_formatter;
  logic        i_clk_sys = 1'b0;
  logic        i_arst_n = 1'b0;
  logic        i_ce = 1'b1;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic [3:0]  i_pstrb = 4'hF;
  logic        i_pix_valid = 1'b0;
  logic [7:0]  i_pix_red = 8'h00;
  logic [7:0]  i_pix_green = 8'h00;
  logic [7:0]  i_pix_blue = 8'h00;
  logic        i_pix_line_start = 1'b0;
  logic        i_pix_vsync = 1'b0;
  logic        i_pix_clk = 1'b0;
  logic [31:0] o_prdata;
  logic        o_pready, o_pslverr, o_pix_ready, o_horizontal_sync_out;
  logic        o_vertical_sync_out, o_pixel_out_clock, o_pixel_out_clock_oe;
  logic [7:0]  o_red_primary_byte, o_red_secondary_byte;
  logic [7:0]  o_green_primary_byte, o_green_secondary_byte;
  logic [7:0]  o_blue_primary_byte, o_blue_secondary_byte;
  logic        o_red_primary_byte_oe, o_red_secondary_byte_oe;
  logic        o_green_primary_byte_oe, o_green_secondary_byte_oe;
  logic        o_blue_primary_byte_oe, o_blue_secondary_byte_oe;
  logic        o_red_converter_sleep, o_green_converter_sleep;
  logic        o_blue_converter_sleep, o_pll_sleep;
  logic        rise_l = 1'b0;
  logic        opp = 1'b0;
  logic [5:0]  oe;
  logic [23:0] cap_p, cap_s;
  logic [1:0]  cap_hv;
  int          caps, hs_high, perrs;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [31:0] rng = 32'h0000_89EA;
  logic [11:0] ofs [4] = '{afpo_pkg::OFS_FORMAT, afpo_pkg::OFS_HS_WIDTH,
                           afpo_pkg::OFS_FLOAT, afpo_pkg::OFS_POWER};
  assign oe = {o_blue_secondary_byte_oe, o_blue_primary_byte_oe,
               o_green_secondary_byte_oe, o_green_primary_byte_oe,
               o_red_secondary_byte_oe, o_red_primary_byte_oe};
  always #5 i_clk_sys = ~i_clk_sys;
  // Pixel clock is offset so its edges never line up with the bus clock
  initial #3 forever #62.5 i_pix_clk = ~i_pix_clk;
  afpo_formatter i_dut (.*);
  afpo_capture_model i_cap (
    .i_rise_launch (rise_l),
    .i_opp         (opp),
    .i_clk         (o_pixel_out_clock),
    .i_clk_oe      (o_pixel_out_clock_oe),
    .i_pri ({o_red_primary_byte, o_green_primary_byte, o_blue_primary_byte}),
    .i_sec ({o_red_secondary_byte, o_green_secondary_byte,
             o_blue_secondary_byte}),
    .i_oe          (oe),
    .i_hs          (o_horizontal_sync_out),
    .i_vs          (o_vertical_sync_out),
    .o_pri         (cap_p),
    .o_sec         (cap_s),
    .o_hv          (cap_hv),
    .o_caps        (caps),
    .o_hs_high     (hs_high),
    .o_errs        (perrs)
  );
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [47:0] exp_bus(input logic [23:0] ev,
    input logic [23:0] od, input logic [7:0] f, input logic [5:0] fl,
    input logic [2:0] sl);
    logic [23:0] a;
    logic [23:0] b;
    logic [23:0] m;
    logic [47:0] x;
    // 4:2:2 lanes: red carries chroma, green luma, blue held low
    a = f[4] ? {ev[7:0], ev[15:8], 8'h00} : ev;
    b = f[4] ? {f[3] ? od[23:16] : ev[23:16], od[15:8], 8'h00} : od;
    m = {{8{~sl[0]}}, {8{~sl[1]}}, {8{~sl[2]}}};
    x = !f[0] ? {b, 24'h0} : f[2] ? {b, a} : {a, b};
    return x & {m, m} & {{8{~fl[0]}}, {8{~fl[2]}}, {8{~fl[4]}},
                         {8{~fl[1]}}, {8{~fl[3]}}, {8{~fl[5]}}};
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do
      @(posedge i_clk_sys);
    while (o_pready !== 1'b1);
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  task automatic wreg(input logic [11:0] a, input logic [7:0] v,
    input logic [7:0] m);
    logic [31:0] q;
    logic        e;
    q = rnd();
    apb(1'b1, a, {q[23:0], v}, q, e);
    apb(1'b0, a, 32'h0, q, e);
    chk("readback", {24'h0, v & m}, q);
  endtask
  task automatic push(input logic [23:0] w, input logic ls);
    i_pix_valid <= 1'b1;
    {i_pix_red, i_pix_green, i_pix_blue} <= w;
    i_pix_line_start <= ls;
    do
      @(posedge i_clk_sys);
    while (o_pix_ready !== 1'b1);
  endtask
  task automatic wait_caps(input int k);
    int c0;
    c0 = caps;
    while (caps < c0 + k)
      @(posedge i_clk_sys);
  endtask
  always @(posedge i_clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] q;
    logic [31:0] r;
    logic        e;
    logic        v;
    logic [7:0]  f;
    logic [5:0]  fl;
    logic [2:0]  sl;
    logic [7:0]  wd;
    logic [23:0] px [4];
    logic [47:0] ex;
    int          c0;
    int          h0;
    int          e0;
    repeat (6) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, ofs[i], 32'h0, q, e);
      chk("reset value", 32'h0, q);
    end
    chk("reset enables", 32'h7F, {o_pixel_out_clock_oe, oe});
    apb(1'b1, 12'h010, 32'hFFFF_FFFF, q, e);
    chk("unmapped write", 32'h1, {31'h0, e});
    apb(1'b0, 12'h006, 32'h0, q, e);
    chk("unaligned read", 32'h1, {q[30:0], e});
    i_pstrb <= 4'hE;
    apb(1'b1, afpo_pkg::OFS_HS_WIDTH, 32'h0000_00FF, q, e);
    i_pstrb <= 4'hF;
    apb(1'b0, afpo_pkg::OFS_HS_WIDTH, 32'h0, q, e);
    chk("strobe off", 32'h0, q);
    $display("test registers done");
    for (int i = 0; i < 8; i++)
    begin
      r = 32'h1 << i;
      wreg(afpo_pkg::OFS_FLOAT, r[7:0], 8'hFF);
      @(posedge i_clk_sys);
      chk("enables", {~(r[6] | r[7]), ~r[5:0]},
          {o_pixel_out_clock_oe, oe});
    end
    $display("test float done");
    for (int t = 0; t < 14; t++)
    begin
      r  = rnd();
      f  = (t == 1) ? 8'hFF : (t == 0) ? 8'h00 : (t == 2) ? 8'h18 :
           (t == 3) ? 8'h05 : r[7:0];
      f[2] = f[2] & f[0];
      fl = (t < 2) ? 6'h00 : r[13:8] & r[21:16];
      sl = f[4] ? 3'h0 : r[24:22] & r[27:25];
      wd = 8'h01 + f[0] + r[28];
      v  = r[29];
      wreg(afpo_pkg::OFS_FORMAT, f, 8'hFF);
      wreg(afpo_pkg::OFS_HS_WIDTH, wd, 8'hFF);
      wreg(afpo_pkg::OFS_FLOAT, {2'h0, fl}, 8'hFF);
      wreg(afpo_pkg::OFS_POWER, {5'h0, sl}, 8'h0F);
      chk("sleeps", {1'b0, sl}, {o_pll_sleep, o_blue_converter_sleep,
          o_green_converter_sleep, o_red_converter_sleep});
      rise_l <= f[5];
      opp <= f[1];
      i_pix_vsync <= v;
      wait_caps(3);
      c0 = caps;
      h0 = hs_high;
      e0 = perrs;
      for (int k = 0; k < 4; k++)
      begin
        r = rnd();
        px[k] = r[23:0];
        push(px[k], k == 0);
      end
      i_pix_valid <= 1'b0;
      wait_caps(wd + 6);
      ex = exp_bus(px[2], px[3], f, fl, sl);
      chk("primary", ex[47:24], cap_p);
      chk("secondary", ex[23:0], cap_s);
      chk("sync idle", {f[7], v ^ f[6]}, cap_hv);
      c0 = f[7] ? caps - c0 - hs_high + h0 : hs_high - h0;
      chk("sync pulse", wd, c0);
      chk("launch edge", 32'h0, perrs - e0);
    end
    $display("test lines done");
    wreg(afpo_pkg::OFS_POWER, 8'h08, 8'h0F);
    c0 = caps;
    repeat (60) @(posedge i_clk_sys);
    chk("stopped clock", c0, caps);
    chk("clock level", 32'h0, {31'h0, o_pixel_out_clock});
    wreg(afpo_pkg::OFS_POWER, 8'h00, 8'h0F);
    wait_caps(2);
    chk("clock resumes", 32'h1, {31'h0, caps > c0 + 1});
    $display("test power done");
    end_of_test();
  end
endmodule

// >>> logic/afpo_formatter.sv
`timescale 1ns/1ps
// Function
// RQ1: Narrow bus: primary only, secondary bytes low
// RQ2: Opposite-edge bit moves secondary to other edge
// RQ3: Swap bit puts first pixel on secondary
// RQ4: Chroma order picks V from even or odd
// RQ5: 4:2:2 mode decimates, blue driven low
// RQ6: Outputs change on edge chosen by polarity
// RQ7: Independent sync output polarities
// RQ8: Software keeps sync width within minimum
// RQ9: Each output byte has own float bit
// RQ10: Float bits override every other output setting
// RQ11: Either of two bits floats pixel clock
// RQ12: Converter sleep bits stop their channel
// RQ13: PLL sleep stops pixel timing
// RQ14: Fields reset zero, reserved bits read zero
module afpo_formatter (
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  input  wire logic        i_ce,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_pix_valid,
  output logic             o_pix_ready,
  input  wire logic [7:0]  i_pix_red,
  input  wire logic [7:0]  i_pix_green,
  input  wire logic [7:0]  i_pix_blue,
  input  wire logic        i_pix_line_start,
  input  wire logic        i_pix_vsync,
  input  wire logic        i_pix_clk,
  output logic             o_pixel_out_clock,
  output logic             o_pixel_out_clock_oe,
  output logic      [7:0]  o_red_primary_byte,
  output logic             o_red_primary_byte_oe,
  output logic      [7:0]  o_red_secondary_byte,
  output logic             o_red_secondary_byte_oe,
  output logic      [7:0]  o_green_primary_byte,
  output logic             o_green_primary_byte_oe,
  output logic      [7:0]  o_green_secondary_byte,
  output logic             o_green_secondary_byte_oe,
  output logic      [7:0]  o_blue_primary_byte,
  output logic             o_blue_primary_byte_oe,
  output logic      [7:0]  o_blue_secondary_byte,
  output logic             o_blue_secondary_byte_oe,
  output logic             o_horizontal_sync_out,
  output logic             o_vertical_sync_out,
  output logic             o_red_converter_sleep,
  output logic             o_green_converter_sleep,
  output logic             o_blue_converter_sleep,
  output logic             o_pll_sleep
);

  // ----------------------------------------------------------------
  // Registers and APB slave
  // ----------------------------------------------------------------
  logic [7:0]  fmt_reg;
  logic [7:0]  hs_len_reg;
  logic [7:0]  float_reg;
  logic [3:0]  pwr_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;

  wire hit_fmt   = (i_paddr == afpo_pkg::OFS_FORMAT);
  wire hit_hs    = (i_paddr == afpo_pkg::OFS_HS_WIDTH);
  wire hit_float = (i_paddr == afpo_pkg::OFS_FLOAT);
  wire hit_pwr   = (i_paddr == afpo_pkg::OFS_POWER);
  wire hit_any   = hit_fmt | hit_hs | hit_float | hit_pwr;
  wire apb_acc   = i_ce & i_psel & i_penable;
  wire apb_first = apb_acc & ~pready_reg;
  wire apb_done  = apb_acc & pready_reg;
  wire apb_wr    = apb_done & i_pwrite & i_pstrb[0];

  // Reserved bits read zero and ignore writes [RQ14]
  wire [31:0] rd_mux =
      hit_fmt   ? {24'h000000, fmt_reg}    :
      hit_hs    ? {24'h000000, hs_len_reg} :
      hit_float ? {24'h000000, float_reg}  :
      hit_pwr   ? {28'h0000000, pwr_reg}   : 32'h00000000;

  // One wait state: answer on the second access cycle
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end
    else if (i_ce)
    begin
      pready_reg  <= apb_first;
      pslverr_reg <= apb_first & ~hit_any;
      if (apb_first)
        prdata_reg <= i_pwrite ? 32'h00000000 : rd_mux;
    end
  end

  // Everything comes up zero: narrow, unswapped, driven, powered [RQ14]
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      fmt_reg    <= afpo_pkg::RST_FORMAT;
      hs_len_reg <= afpo_pkg::RST_HS_WIDTH;
      float_reg  <= afpo_pkg::RST_FLOAT;
      pwr_reg    <= afpo_pkg::RST_POWER;
    end
    else if (apb_wr)
    begin
      if (hit_fmt)
        fmt_reg <= i_pwdata[7:0];
      if (hit_hs)
        hs_len_reg <= i_pwdata[7:0];
      if (hit_float)
        float_reg <= i_pwdata[7:0];
      if (hit_pwr)
        pwr_reg <= i_pwdata[3:0];
    end
  end

  wire wide  = fmt_reg[afpo_pkg::FMT_WIDE];
  wire opp   = fmt_reg[afpo_pkg::FMT_OPP];
  wire swap  = fmt_reg[afpo_pkg::FMT_SWAP];
  wire chord = fmt_reg[afpo_pkg::FMT_CHORD];
  wire m422  = fmt_reg[afpo_pkg::FMT_422];
  wire ckpol = fmt_reg[afpo_pkg::FMT_CKPOL];
  wire vpol  = fmt_reg[afpo_pkg::FMT_VPOL];
  wire hpol  = fmt_reg[afpo_pkg::FMT_HPOL];
  wire pll_off = pwr_reg[afpo_pkg::PWR_PLL];

  // ----------------------------------------------------------------
  // Pixel clock sampling
  // ----------------------------------------------------------------
  logic clk_meta_reg;
  logic clk_sync_reg;
  logic clk_prev_reg;
  logic clk_out_reg;
  logic clk_oe_reg;

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      clk_meta_reg <= 1'b0;
      clk_sync_reg <= 1'b0;
      clk_prev_reg <= 1'b0;
      clk_out_reg  <= 1'b0;
      clk_oe_reg   <= 1'b0;
    end
    else if (i_ce)
    begin
      clk_meta_reg <= i_pix_clk;
      clk_sync_reg <= clk_meta_reg;
      clk_prev_reg <= clk_sync_reg;
      clk_out_reg  <= clk_sync_reg & ~pll_off;  // [RQ13]
      clk_oe_reg   <= ~(float_reg[afpo_pkg::FLT_CLK_A]
                      | float_reg[afpo_pkg::FLT_CLK_B]);  // [RQ11]
    end
  end

  wire clk_rise = clk_sync_reg & ~clk_prev_reg;
  wire clk_fall = ~clk_sync_reg & clk_prev_reg;
  // The output clock copy toggles one cycle after these ticks, on the edge that loads the data they launch
  wire run      = i_ce & ~pll_off;                         // [RQ13]
  wire launch   = run & (ckpol ? clk_rise : clk_fall);     // [RQ6]
  wire opposite = run & (ckpol ? clk_fall : clk_rise);     // [RQ2]

  // ----------------------------------------------------------------
  // Two-entry input buffer
  // ----------------------------------------------------------------
  logic [afpo_pkg::WORD_W-1:0] ent_reg [0:1];
  logic [1:0] cnt_reg;
  logic       ready_reg;
  logic       pop;

  wire push = i_pix_valid & ready_reg;
  wire [1:0] cnt_next = 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
  wire wr_idx = pop ? 1'b0 : cnt_reg[0];
  wire [afpo_pkg::WORD_W-1:0] in_word =
      {i_pix_vsync, i_pix_line_start, i_pix_red, i_pix_green, i_pix_blue};

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ent_reg[0] <= '0;
      ent_reg[1] <= '0;
      cnt_reg    <= 2'h0;
      ready_reg  <= 1'b0;
    end
    else if (i_ce)
    begin
      if (pop)
        ent_reg[0] <= ent_reg[1];
      if (push)
        ent_reg[wr_idx] <= in_word;
      cnt_reg   <= cnt_next;
      ready_reg <= (cnt_next != afpo_pkg::BUF_FULL);
    end
  end

  // ----------------------------------------------------------------
  // Line sequencing and sync generation
  // ----------------------------------------------------------------
  logic [7:0]  hs_cnt_reg;
  logic        hs_done_reg;
  logic        slot_reg;
  logic        vs_lvl_reg;
  logic [23:0] hold_reg;
  logic        hs_out_reg;
  logic        vs_out_reg;

  wire [afpo_pkg::WORD_W-1:0] head = ent_reg[0];
  wire head_sol = head[afpo_pkg::W_SOL];
  wire have     = (cnt_reg != 2'h0);
  wire hs_idle  = (hs_cnt_reg == 8'h00);
  // Zero length skips the pulse rather than stalling the line
  wire need_hs  = head_sol & ~hs_done_reg & (hs_len_reg != 8'h00);
  wire start_hs = launch & have & hs_idle & need_hs;
  assign pop    = launch & have & hs_idle & ~need_hs;
  wire odd      = head_sol ? 1'b0 : slot_reg;
  wire [7:0] hs_cnt_next =
      start_hs             ? hs_len_reg :
      (launch & ~hs_idle)  ? 8'(hs_cnt_reg - 8'h01) : hs_cnt_reg;
  wire vs_next = pop ? head[afpo_pkg::W_VS] : vs_lvl_reg;

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      hs_cnt_reg  <= 8'h00;
      hs_done_reg <= 1'b0;
      slot_reg    <= 1'b0;
      vs_lvl_reg  <= 1'b0;
      hold_reg    <= 24'h000000;
      hs_out_reg  <= 1'b0;
      vs_out_reg  <= 1'b0;
    end
    else if (i_ce)
    begin
      hs_cnt_reg <= hs_cnt_next;
      if (start_hs)
        hs_done_reg <= 1'b1;
      else if (pop & head_sol)
        hs_done_reg <= 1'b0;
      if (pop)
      begin
        slot_reg   <= ~odd;
        vs_lvl_reg <= head[afpo_pkg::W_VS];
      end
      if (pop & ~odd)
        hold_reg <= head[23:0];
      if (launch)
      begin
        hs_out_reg <= (hs_cnt_next != 8'h00) ^ hpol;  // [RQ6] [RQ7]
        vs_out_reg <= vs_next ^ vpol;                 // [RQ6] [RQ7]
      end
    end
  end

  // ----------------------------------------------------------------
  // Pixel formatting and bus steering
  // ----------------------------------------------------------------
  function automatic logic [23:0] fmt_pix(
    input logic [23:0] w,
    input logic        is_odd,
    input logic [23:0] held,
    input logic        dec,
    input logic        v_from_odd,
    input logic [2:0]  slp
  );
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    r = w[23:16];
    g = w[15:8];
    b = w[7:0];
    // Chroma rides the red bus: U on even, V on odd [RQ4] [RQ5]
    if (dec)
    begin
      r = is_odd ? (v_from_odd ? w[23:16] : held[23:16]) : w[7:0];
      b = 8'h00;
    end
    // A sleeping converter delivers zeros [RQ12]
    if (slp[0])
      r = 8'h00;
    if (slp[1])
      g = 8'h00;
    if (slp[2])
      b = 8'h00;
    return {r, g, b};
  endfunction

  logic [23:0] pri_reg;
  logic [23:0] sec_reg;
  logic [23:0] pend_reg;
  logic        pend_v_reg;
  logic [23:0] pri_next;
  logic [23:0] sec_next;
  logic [23:0] pend_next;
  logic        pend_v_next;
  logic [5:0]  oe_reg;

  wire [2:0]  slp = pwr_reg[2:0];
  wire [23:0] pix_cur  = fmt_pix(head[23:0], odd, hold_reg, m422, chord, slp);
  wire [23:0] pix_held = fmt_pix(hold_reg, 1'b0, hold_reg, m422, chord, slp);

  always_comb
  begin
    pri_next    = pri_reg;
    sec_next    = sec_reg;
    pend_next   = pend_reg;
    pend_v_next = pend_v_reg;
    if (pop)
    begin
      if (!wide)
      begin
        pri_next = pix_cur;       // [RQ1]
        sec_next = 24'h000000;    // [RQ1]
      end
      else if (opp)
      begin
        // Secondary half waits for the opposite tick [RQ2] [RQ3]
        if (odd ^ swap)
        begin
          pend_next   = pix_cur;
          pend_v_next = 1'b1;
        end
        else
          pri_next = pix_cur;
      end
      else if (odd)
      begin
        // Both halves of the pair move on the same edge [RQ2] [RQ3]
        pri_next = swap ? pix_cur : pix_held;
        sec_next = swap ? pix_held : pix_cur;
      end
    end
    if (opposite && pend_v_reg && opp)
    begin
      sec_next    = pend_reg;     // [RQ2]
      pend_v_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pri_reg    <= 24'h000000;
      sec_reg    <= 24'h000000;
      pend_reg   <= 24'h000000;
      pend_v_reg <= 1'b0;
      oe_reg     <= 6'h00;
    end
    else if (i_ce)
    begin
      pri_reg    <= pri_next;
      sec_reg    <= sec_next;
      pend_reg   <= pend_next;
      pend_v_reg <= pend_v_next;
      oe_reg     <= ~float_reg[5:0];  // [RQ9] [RQ10]
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_prdata                  = prdata_reg;
  assign o_pready                  = pready_reg;
  assign o_pslverr                 = pslverr_reg;
  assign o_pix_ready               = ready_reg;
  assign o_pixel_out_clock         = clk_out_reg;
  assign o_pixel_out_clock_oe      = clk_oe_reg;
  assign o_red_primary_byte        = pri_reg[23:16];
  assign o_green_primary_byte      = pri_reg[15:8];
  assign o_blue_primary_byte       = pri_reg[7:0];
  assign o_red_secondary_byte      = sec_reg[23:16];
  assign o_green_secondary_byte    = sec_reg[15:8];
  assign o_blue_secondary_byte     = sec_reg[7:0];
  assign o_red_primary_byte_oe     = oe_reg[0];
  assign o_red_secondary_byte_oe   = oe_reg[1];
  assign o_green_primary_byte_oe   = oe_reg[2];
  assign o_green_secondary_byte_oe = oe_reg[3];
  assign o_blue_primary_byte_oe    = oe_reg[4];
  assign o_blue_secondary_byte_oe  = oe_reg[5];
  assign o_horizontal_sync_out     = hs_out_reg;
  assign o_vertical_sync_out       = vs_out_reg;
  assign o_red_converter_sleep     = pwr_reg[afpo_pkg::PWR_RED];   // [RQ12]
  assign o_green_converter_sleep   = pwr_reg[afpo_pkg::PWR_GREEN]; // [RQ12]
  assign o_blue_converter_sleep    = pwr_reg[afpo_pkg::PWR_BLUE];  // [RQ12]
  assign o_pll_sleep               = pll_off;                      // [RQ13]

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  sequence narrow_pop_s;
    pop && !wide;
  endsequence

  narrow_sec_low_a: assert property ( // [RQ1]
    narrow_pop_s |=> (sec_reg == 24'h000000))
    else $error("secondary bytes not low in narrow mode");

  sec_same_edge_a: assert property ( // [RQ2]
    ($changed(sec_reg) && !$past(opp)) |-> $past(launch))
    else $error("secondary moved off the launch edge");

  sec_opp_edge_a: assert property ( // [RQ2]
    ($changed(sec_reg) && $past(opp) && $past(wide)) |-> $past(opposite))
    else $error("secondary moved off the opposite edge");

  swap_first_a: assert property ( // [RQ3]
    (pop && wide && odd && !opp && swap) |=> (sec_reg == $past(pix_held)))
    else $error("swap did not route first pixel to secondary");

  chroma_odd_a: assert property ( // [RQ4]
    (narrow_pop_s and (m422 && odd && chord && !slp[0]))
      |=> (pri_reg[23:16] == $past(head[23:16])))
    else $error("odd chroma not taken from odd pixel");

  blue_low_a: assert property ( // [RQ5]
    (narrow_pop_s and m422) |=> (pri_reg[7:0] == 8'h00))
    else $error("blue not low in decimated mode");

  launch_edge_a: assert property ( // [RQ6]
    ($changed(pri_reg) || $changed(hs_out_reg)) |-> $past(launch))
    else $error("output changed off the launch edge");

  hs_polarity_a: assert property ( // [RQ7]
    launch |=> (hs_out_reg == ((hs_cnt_reg != 8'h00) ^ $past(hpol))))
    else $error("horizontal sync level or polarity wrong");

  byte_float_a: assert property ( // [RQ9]
    (i_ce && float_reg[0]) |=> !o_red_primary_byte_oe)
    else $error("floated byte still driven");

  float_wins_a: assert property ( // [RQ10]
    (i_ce && float_reg[1] && wide) |=> !o_red_secondary_byte_oe)
    else $error("float bit lost to bus width");

  clk_float_a: assert property ( // [RQ11]
    (i_ce && (float_reg[6] || float_reg[7])) |=> !o_pixel_out_clock_oe)
    else $error("pixel clock driven while floated");

  red_sleep_a: assert property ( // [RQ12]
    (narrow_pop_s and slp[0]) |=> (pri_reg[23:16] == 8'h00))
    else $error("sleeping red channel produced data");

  pll_stop_a: assert property ( // [RQ13]
    pll_off |-> (!launch && !opposite && !pop))
    else $error("pixel timing ran with pll asleep");

  rsvd_zero_a: assert property ( // [RQ14]
    o_pready |-> (o_prdata[31:8] == 24'h000000))
    else $error("reserved read bits not zero");

endmodule

// >>> logic/afpo_pkg.sv
package afpo_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_FORMAT   = 12'h000;
  localparam logic [11:0] OFS_HS_WIDTH = 12'h004;
  localparam logic [11:0] OFS_FLOAT    = 12'h008;
  localparam logic [11:0] OFS_POWER    = 12'h00C;

  localparam logic [7:0] RST_FORMAT   = 8'h00;
  localparam logic [7:0] RST_HS_WIDTH = 8'h00;
  localparam logic [7:0] RST_FLOAT    = 8'h00;
  localparam logic [3:0] RST_POWER    = 4'h0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned FMT_WIDE  = 0;
  localparam int unsigned FMT_OPP   = 1;
  localparam int unsigned FMT_SWAP  = 2;
  localparam int unsigned FMT_CHORD = 3;
  localparam int unsigned FMT_422   = 4;
  localparam int unsigned FMT_CKPOL = 5;
  localparam int unsigned FMT_VPOL  = 6;
  localparam int unsigned FMT_HPOL  = 7;

  // Float bits 0..5: red pri, red sec, green pri, green sec, blue pri,
  // blue sec; 6 and 7 each float the pixel clock
  localparam int unsigned FLT_CLK_A = 6;
  localparam int unsigned FLT_CLK_B = 7;

  localparam int unsigned PWR_RED   = 0;
  localparam int unsigned PWR_GREEN = 1;
  localparam int unsigned PWR_BLUE  = 2;
  localparam int unsigned PWR_PLL   = 3;

  // ----------------------------------------------------------------
  // Pixel word in the buffer
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W   = 26;
  localparam int unsigned W_SOL    = 24;
  localparam int unsigned W_VS     = 25;
  localparam logic [1:0]  BUF_FULL = 2'h2;

endpackage
